/* File: tracker_cfg.svh */
`ifndef TRACKER_CFG_SVH
`define TRACKER_CFG_SVH

`define CLK_NS      25
`define UPDATE_US   2000
`define UPDATE_CYC  ((`UPDATE_US * 1000) / `CLK_NS)
`define DEAD_NS     100
`define DEAD_CYC    ((`DEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define START_DUTY  8'h10
`define DUTY_MIN    8'h04
`define DUTY_MAX    8'hE6
`define SHORT_LIMIT 8'hF0
`define VMIN_CODE   8'h20
`define OPEN_MV     550
`define ADC_FULL_MV 1024
`define OPEN_CODE   (8'((`OPEN_MV * 256) / `ADC_FULL_MV))
`define STEP_SHIFT  4
`define STEP_MAX    4
`define TOL_PERMIL  25

`endif

/* File: tracker_pkg.sv */
package tracker_pkg;

    typedef enum logic [1:0] {
        ST_START  = 2'b00,
        ST_WAIT   = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_DECIDE = 2'b11
    } track_state_t;

    typedef struct packed {
        logic [7:0] voltage;
        logic [7:0] current;
    } sense_t;

    typedef logic [7:0] duty_t;

endpackage

/* File: dead_time_pwm.sv */
`timescale 1ns/1ps
`include "tracker_cfg.svh"
module dead_time_pwm (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire tracker_pkg::duty_t duty,
    input  wire logic               enable,
    output logic                    pwmHigh,
    output logic                    pwmLow
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       lastRaw;
    logic       next_lastRaw;
    logic [2:0] deadCnt;
    logic [2:0] next_deadCnt;
    logic       next_pwmHigh;
    logic       next_pwmLow;
    logic       raw;

    assign raw = cnt < duty;

    always_comb begin
        next_cnt     = cnt + 8'h01;
        next_lastRaw = raw;
        next_deadCnt = deadCnt;
        next_pwmHigh = 1'b0;
        next_pwmLow  = 1'b0;
        // Disabling also rearms the gap, so re-enable cannot shoot through
        if (!enable || raw != lastRaw) begin
            next_deadCnt = 3'(`DEAD_CYC);
        end else if (deadCnt != 3'h0) begin
            next_deadCnt = deadCnt - 3'h1;
        end else begin
            next_pwmLow  = raw;
            next_pwmHigh = ~raw;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt     <= 8'h00;
            lastRaw <= 1'b0;
            deadCnt <= 3'(`DEAD_CYC);
            pwmHigh <= 1'b0;
            pwmLow  <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            lastRaw <= next_lastRaw;
            deadCnt <= next_deadCnt;
            pwmHigh <= next_pwmHigh;
            pwmLow  <= next_pwmLow;
        end
    end

    default clocking cb @(posedge clk); endclocking

    property p_no_overlap;
        disable iff (!rst_b) !(pwmHigh && pwmLow);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("Both switches on");

    property p_gap_low_high;
        disable iff (!rst_b) $fell(pwmLow) |-> !pwmHigh [*4];
    endproperty
    a_gap_low_high: assert property (p_gap_low_high)
        else $error("No dead gap after low side");

    property p_gap_high_low;
        disable iff (!rst_b) $fell(pwmHigh) |-> !pwmLow [*4];
    endproperty
    a_gap_high_low: assert property (p_gap_high_low)
        else $error("No dead gap after high side");

endmodule

/* File: peak_power_tracker_duty_tracker.sv */
`timescale 1ns/1ps
`include "tracker_cfg.svh"
module peak_power_tracker_duty_tracker #(
    parameter int UPDATE_CYCLES = `UPDATE_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         cellVoltage,
    input  wire logic [7:0]         cellCurrent,
    output logic                    pwmHigh,
    output logic                    pwmLow,
    output logic                    powerDown,
    output logic                    regionB,
    output logic                    atPeak,
    output tracker_pkg::duty_t      duty
);

    // Input synchroniser; ADC codes must be quasi-static between samples
    tracker_pkg::sense_t       senseMeta;
    tracker_pkg::sense_t       next_senseMeta;
    tracker_pkg::sense_t       senseSync;
    tracker_pkg::sense_t       next_senseSync;

    // Update tick
    logic [23:0]               tickCnt;
    logic [23:0]               next_tickCnt;
    logic                      tick;
    logic                      next_tick;

    // Tracking state
    tracker_pkg::track_state_t state;
    tracker_pkg::track_state_t next_state;
    tracker_pkg::sense_t       curSense;
    tracker_pkg::sense_t       next_curSense;
    tracker_pkg::sense_t       prevSense;
    tracker_pkg::sense_t       next_prevSense;
    logic [15:0]               curPower;
    logic [15:0]               next_curPower;
    logic [15:0]               prevPower;
    logic [15:0]               next_prevPower;
    tracker_pkg::duty_t        next_duty;
    logic                      next_regionB;
    logic                      next_atPeak;
    logic                      next_powerDown;

    // Decision terms
    logic [15:0]               samplePower;
    logic                      powerUp;
    logic                      powerSame;
    logic                      voltageDown;
    logic                      regionNow;
    logic                      nearShort;
    logic                      goUp;
    logic [15:0]               powerDelta;
    logic                      inBand;
    logic [7:0]                currentDelta;
    logic [7:0]                coarse;
    logic [7:0]                step;
    logic [8:0]                raised;
    tracker_pkg::duty_t        dutyUp;
    tracker_pkg::duty_t        dutyDown;

    always_comb begin
        next_senseMeta = {cellVoltage, cellCurrent};
        next_senseSync = senseMeta;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            senseMeta <= 16'h0000;
            senseSync <= 16'h0000;
        end else begin
            senseMeta <= next_senseMeta;
            senseSync <= next_senseSync;
        end
    end

    // Slow tick; far below the 256-cycle PWM period rate
    always_comb begin
        next_tickCnt = tickCnt + 24'h000001;
        next_tick    = 1'b0;
        if (tickCnt >= 24'(UPDATE_CYCLES - 1)) begin
            next_tickCnt = 24'h000000;
            next_tick    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tickCnt <= 24'h000000;
            tick    <= 1'b0;
        end else begin
            tickCnt <= next_tickCnt;
            tick    <= next_tick;
        end
    end

    assign samplePower = senseSync.voltage * senseSync.current;

    always_comb begin
        powerUp     = curPower > prevPower;
        powerSame   = curPower == prevPower;
        voltageDown = curSense.voltage < prevSense.voltage;
        // Flat power: no new evidence, so keep probing the same way
        regionNow   = powerSame ? regionB
                                : ~(powerUp ^ voltageDown);
        nearShort   = curSense.current >= `SHORT_LIMIT;
        goUp        = regionNow && !nearShort;
        powerDelta  = powerUp ? curPower - prevPower
                              : prevPower - curPower;
        inBand      = (32'(powerDelta) * 32'd1000)
                      <= (32'(curPower) * 32'(`TOL_PERMIL));
        currentDelta = (curSense.current > prevSense.current)
                       ? curSense.current - prevSense.current
                       : prevSense.current - curSense.current;
        coarse = currentDelta >> `STEP_SHIFT;
        if (inBand) begin
            step = 8'h01;
        end else if (coarse >= 8'(`STEP_MAX - 1)) begin
            step = 8'(`STEP_MAX);
        end else begin
            step = coarse + 8'h01;
        end
        raised = {1'b0, duty} + {1'b0, step};
        dutyUp = (raised > {1'b0, `DUTY_MAX}) ? `DUTY_MAX : raised[7:0];
        if ({1'b0, duty} < ({1'b0, `DUTY_MIN} + {1'b0, step})) begin
            dutyDown = `DUTY_MIN;
        end else begin
            dutyDown = duty - step;
        end
    end

    always_comb begin
        next_state     = state;
        next_curSense  = curSense;
        next_prevSense = prevSense;
        next_curPower  = curPower;
        next_prevPower = prevPower;
        next_duty      = duty;
        next_regionB   = regionB;
        next_atPeak    = atPeak;
        next_powerDown = senseSync.voltage < `VMIN_CODE;
        case (state)
            tracker_pkg::ST_START: begin
                next_duty    = `START_DUTY;
                next_regionB = 1'b1;
                next_atPeak  = 1'b0;
                // Only begin once the cell sits near its open-load voltage
                if (tick && senseSync.voltage >= `OPEN_CODE) begin
                    next_prevSense = senseSync;
                    next_prevPower = samplePower;
                    next_state     = tracker_pkg::ST_WAIT;
                end
            end
            tracker_pkg::ST_WAIT: begin
                if (tick) begin
                    next_state = tracker_pkg::ST_SAMPLE;
                end
            end
            tracker_pkg::ST_SAMPLE: begin
                next_curSense = senseSync;
                next_curPower = samplePower;
                next_state    = tracker_pkg::ST_DECIDE;
            end
            tracker_pkg::ST_DECIDE: begin
                next_regionB   = regionNow;
                next_atPeak    = inBand;
                next_duty      = goUp ? dutyUp : dutyDown;
                next_prevSense = curSense;
                next_prevPower = curPower;
                next_state     = tracker_pkg::ST_WAIT;
            end
            default: begin
                next_state = tracker_pkg::ST_START;
            end
        endcase
        // Light lost: stop switching and restart from the open point
        if (powerDown) begin
            next_state = tracker_pkg::ST_START;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= tracker_pkg::ST_START;
            curSense  <= 16'h0000;
            prevSense <= 16'h0000;
            curPower  <= 16'h0000;
            prevPower <= 16'h0000;
            duty      <= `START_DUTY;
            regionB   <= 1'b1;
            atPeak    <= 1'b0;
            powerDown <= 1'b1;
        end else begin
            state     <= next_state;
            curSense  <= next_curSense;
            prevSense <= next_prevSense;
            curPower  <= next_curPower;
            prevPower <= next_prevPower;
            duty      <= next_duty;
            regionB   <= next_regionB;
            atPeak    <= next_atPeak;
            powerDown <= next_powerDown;
        end
    end

    dead_time_pwm u_pwm (
        .clk     (clk),
        .rst_b   (rst_b),
        .duty    (duty),
        .enable  (!powerDown),
        .pwmHigh (pwmHigh),
        .pwmLow  (pwmLow)
    );

    default clocking cb @(posedge clk); endclocking

    property p_region_right;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && !powerSame
         && powerUp && voltageDown) |=> regionB;
    endproperty
    a_region_right: assert property (p_region_right)
        else $error("Right of peak not flagged");

    property p_region_left;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && !powerSame
         && powerUp && !voltageDown) |=> !regionB;
    endproperty
    a_region_left: assert property (p_region_left)
        else $error("Left of peak not flagged");

    property p_raise;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && goUp
         && duty < `DUTY_MAX) |=> duty > $past(duty);
    endproperty
    a_raise: assert property (p_raise)
        else $error("Duty not raised in region B");

    property p_step_bound;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown) |=>
        ((duty >= $past(duty)) ? (duty - $past(duty))
                               : ($past(duty) - duty)) <= `STEP_MAX;
    endproperty
    a_step_bound: assert property (p_step_bound)
        else $error("Duty step too large");

    property p_keep_dir;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && powerSame)
        |=> regionB == $past(regionB);
    endproperty
    a_keep_dir: assert property (p_keep_dir)
        else $error("Direction changed on flat power");

    property p_start;
        (!rst_b) |=> (duty == `START_DUTY && regionB
                      && state == tracker_pkg::ST_START);
    endproperty
    a_start: assert property (p_start)
        else $error("Wrong start-up point");

    property p_tick_spacing;
        disable iff (!rst_b) tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("Update ticks too close");

    property p_duty_on_update;
        disable iff (!rst_b)
        (duty != $past(duty) && $past(rst_b)) |->
        ($past(state) == tracker_pkg::ST_DECIDE
         || $past(state) == tracker_pkg::ST_START);
    endproperty
    a_duty_on_update: assert property (p_duty_on_update)
        else $error("Duty changed outside an update");

    property p_interval;
        disable iff (!rst_b) tickCnt < 24'(UPDATE_CYCLES);
    endproperty
    a_interval: assert property (p_interval)
        else $error("Tick counter past interval");

    property p_short_limit;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && nearShort
         && duty > `DUTY_MIN) |=> duty < $past(duty);
    endproperty
    a_short_limit: assert property (p_short_limit)
        else $error("Duty raised near short circuit");

    property p_power_down;
        disable iff (!rst_b)
        powerDown |-> ##1 (!pwmHigh && !pwmLow
                          && state == tracker_pkg::ST_START);
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("Switching during power-down");

    property p_band;
        disable iff (!rst_b)
        (state == tracker_pkg::ST_DECIDE && !powerDown && inBand) |=>
        (atPeak && ((duty >= $past(duty)) ? (duty - $past(duty))
                                          : ($past(duty) - duty)) <= 1);
    endproperty
    a_band: assert property (p_band)
        else $error("Band not honoured at peak");

    c_region_b: cover property (disable iff (!rst_b) $rose(regionB));
    c_at_peak: cover property (disable iff (!rst_b) $rose(atPeak));
    c_near_short: cover property (disable iff (!rst_b)
        state == tracker_pkg::ST_DECIDE && nearShort);
    c_oscillate: cover property (disable iff (!rst_b)
        $fell(regionB) ##[1:1000] $rose(regionB));

endmodule

/* File: pv_cell_model.sv */
`timescale 1ns/1ps
module pv_cell_model (
    input  wire logic               clk,
    input  wire tracker_pkg::duty_t duty,
    input  wire logic [8:0]         settleCycles,
    input  wire logic               shade,
    input  wire logic [7:0]         shadeLevel,
    input  wire logic               shortMode,
    input  wire logic [7:0]         shortLevel,
    output logic [7:0]              cellVoltage,
    output logic [7:0]              cellCurrent
);
    // Peak power near duty 8'h26; voltage falls as duty rises
    tracker_pkg::duty_t settled = 8'h10;
    logic [8:0]         age     = 9'h000;
    logic [7:0]         nextV;
    logic [7:0]         nextI;
    int                 d;
    always @(posedge clk) begin
        // Lag mimics converter settling after each duty step
        if (!$isunknown(duty) && duty != settled) begin
            if (age >= settleCycles) begin
                settled = duty;
                age     = 9'h000;
            end else begin
                age = age + 9'h001;
            end
        end
        d = (settled > 8'h10) ? int'(settled) - 16 : 0;
        // Controls taken at the edge so bench updates never race the model
        nextV = shade ? shadeLevel : 8'((d > 48) ? 48 : 240 - 4 * d);
        nextI = shortMode ? shortLevel : 8'((d > 40) ? 224 : 64 + 4 * d);
        #2;
        cellVoltage = nextV;
        cellCurrent = nextI;
    end
endmodule

/* File: peak_power_tracker_duty_tracker_bench.sv */
`timescale 1ns/1ps
`include "tracker_cfg.svh"
module peak_power_tracker_duty_tracker_bench;
    localparam int UPD   = 1024;
    localparam int LIMIT = 90000;
    localparam int PEAK  = 38;
    typedef struct packed {
        tracker_pkg::duty_t duty;
        logic               rb;
        logic               pd;
        logic               ph;
        logic               pl;
    } note_t;
    logic               clk;
    logic               rst_b;
    logic [7:0]         cellVoltage;
    logic [7:0]         cellCurrent;
    logic               pwmHigh;
    logic               pwmLow;
    logic               powerDown;
    logic               regionB;
    logic               atPeak;
    tracker_pkg::duty_t duty;
    tracker_pkg::duty_t lastDuty;
    logic [8:0]         settleCycles;
    logic               shade;
    logic               shortMode;
    logic [7:0]         shadeLevel;
    logic [7:0]         shortLevel;
    logic [19:0]        lfsr;
    logic               track;
    logic               primed;
    logic               downSeen;
    logic               peakSeen;
    logic               lastSide;
    int                 fail_count;
    int                 n_compared;
    int                 cycles;
    int                 sinceChange;
    int                 lowRun;
    int                 switches;
    int                 k;
    note_t              notes[$];
    event               checkNow;

    peak_power_tracker_duty_tracker #(.UPDATE_CYCLES(UPD)) dut_u (
        .clk(clk), .rst_b(rst_b), .cellVoltage(cellVoltage),
        .cellCurrent(cellCurrent), .pwmHigh(pwmHigh), .pwmLow(pwmLow),
        .powerDown(powerDown), .regionB(regionB), .atPeak(atPeak),
        .duty(duty)
    );
    pv_cell_model cell_u (
        .clk(clk), .duty(duty), .settleCycles(settleCycles),
        .shade(shade), .shadeLevel(shadeLevel), .shortMode(shortMode),
        .shortLevel(shortLevel), .cellVoltage(cellVoltage),
        .cellCurrent(cellCurrent)
    );

    always #12.5 clk = ~clk;

    function automatic logic [19:0] lfsr_next(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction

    task automatic miss(input string msg);
        fail_count++;
        $display("MISMATCH %0t %s", $time, msg);
    endtask

    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic expect_now(input note_t n);
        notes.push_back(n);
        ->checkNow;
        @(posedge clk);
    endtask

    // Bounded wait for each decision; a stall is reported
    task automatic wait_changes(input int n);
        tracker_pkg::duty_t start;
        int                 w;
        repeat (n) begin
            start = duty;
            w     = 0;
            while (duty === start && w < 4000) begin
                @(negedge clk);
                w++;
            end
            if (w >= 4000) miss("no duty update");
        end
        @(posedge clk);
        #2;
    endtask

    task automatic converge_check();
        n_compared++;
        if (duty > 8'(PEAK + 3) || duty < 8'(PEAK - 3)) miss("not at peak");
        if (downSeen !== 1'b1 || peakSeen !== 1'b1) miss("no oscillation");
        if (atPeak !== 1'b1) miss("peak flag low");
    endtask

    always @(checkNow) begin
        note_t n;
        n = notes.pop_front();
        n_compared++;
        if ({duty, regionB, powerDown, pwmHigh, pwmLow} !== n) miss("outputs");
    end

    always @(negedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            miss("timeout");
            conclude();
        end
    end

    always @(negedge clk) begin
        if (pwmHigh === 1'b1 && pwmLow === 1'b1) miss("overlap");
        if (pwmHigh === 1'b0 && pwmLow === 1'b0) begin
            lowRun++;
        end else begin
            if (pwmLow !== lastSide) begin
                switches++;
                n_compared++;
                if (lowRun < `DEAD_CYC) miss("dead gap short");
            end
            lastSide = pwmLow;
            lowRun   = 0;
        end
        if (atPeak === 1'b1) peakSeen = 1'b1;
        if (duty !== lastDuty) begin
            if (track) begin
                n_compared++;
                if (primed && sinceChange != UPD) miss("interval");
                if (shortMode ? duty >= lastDuty
                    : (regionB === 1'b1) != (duty > lastDuty)) miss("dir");
                if (!shortMode && lastDuty < 8'(PEAK - 1)
                    && regionB !== 1'b1) miss("region");
                if (8'(duty - lastDuty) > 8'h04
                    && 8'(lastDuty - duty) > 8'h04) miss("step");
                if (regionB === 1'b0) downSeen = 1'b1;
                primed = 1'b1;
            end
            sinceChange = 1;
            lastDuty    = duty;
        end else begin
            sinceChange++;
        end
    end

    initial begin
        clk = 1'b0; rst_b = 1'b0; settleCycles = 9'h000;
        shade = 1'b0; shortMode = 1'b0; shadeLevel = 8'h00;
        shortLevel = 8'h00; lfsr = 20'h137C2; track = 1'b0;
        primed = 1'b0; downSeen = 1'b0; peakSeen = 1'b0;
        lastSide = 1'bx; lastDuty = 8'h10;
        fail_count = 0; n_compared = 0; cycles = 0;
        sinceChange = 0; lowRun = 0; switches = 0;
        repeat (7) @(posedge clk);
        #2;
        expect_now({8'h10, 1'b1, 1'b1, 1'b0, 1'b0});
        #2 rst_b = 1'b1;
        track = 1'b1;
        wait_changes(32);
        converge_check();
        // Current pinned near short circuit: duty must only fall
        lfsr       = lfsr_next(lfsr);
        shortLevel = 8'hF0 | {4'h0, lfsr[3:0]};
        shortMode  = 1'b1;
        wait_changes(2);
        shortMode = 1'b0;
        track     = 1'b0;
        // Shaded cell collapses below the power-down threshold
        lfsr       = lfsr_next(lfsr);
        shadeLevel = {3'b000, lfsr[4:0]};
        shade      = 1'b1;
        k          = 0;
        while (powerDown !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        n_compared++;
        // Model edge, two sync flops, then the output flop
        if (k != 5) miss("power-down latency");
        repeat (3) @(posedge clk);
        #2;
        expect_now({8'h10, 1'b1, 1'b1, 1'b0, 1'b0});
        repeat (300) @(posedge clk);
        #2;
        expect_now({8'h10, 1'b1, 1'b1, 1'b0, 1'b0});
        #2;
        shade        = 1'b0;
        settleCycles = 9'd300;
        downSeen     = 1'b0;
        peakSeen     = 1'b0;
        primed       = 1'b0;
        track        = 1'b1;
        wait_changes(34);
        converge_check();
        n_compared++;
        if (switches < 10) miss("pwm idle");
        conclude();
    end
endmodule
